// ==== verilog/aebp_pkg.sv ====
// Purpose: Shared constants for the byte-wide nonvolatile memory host controller
// Assumes: 25 MHz ref_clk
// Notes:   Cycle counts round each minimum time up to whole clocks
package aebp_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 40;
  localparam int unsigned ADDR_W          = 9;
  localparam int unsigned DATA_W          = 8;
  // Strobe phase lengths, least times rounded up
  localparam int unsigned ADDR_SETUP_NS   = 10;
  localparam int unsigned WRITE_PULSE_NS  = 230;
  localparam int unsigned DATA_HOLD_NS    = 50;
  localparam int unsigned READ_ACCESS_NS  = 450;
  localparam int unsigned RECOVERY_NS     = 50;
  localparam int unsigned ADDR_SETUP_CYC  = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DATA_HOLD_CYC   = (DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Two extra cycles cover the input synchroniser
  localparam int unsigned READ_ACCESS_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 2;
  localparam int unsigned RECOVERY_CYC    = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Worst-case write cycle, 10 ms
  localparam int unsigned WRITE_CYCLE_MS  = 10;
  localparam int unsigned WRITE_CYCLE_CYC = WRITE_CYCLE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned POLL_LIMIT      = 4095;
  localparam logic [7:0]  ERASE_DATA      = 8'hff;
  localparam logic [7:0]  POLL_DATA_RST   = 8'h00;
  localparam logic [15:0] CNT_RST         = 16'h0000;
endpackage

// ==== verilog/aebp_host.sv ====
// Purpose: Host controller driving a 512 x 8 self-timed EEPROM over its strobes
// Assumes: Device pins are sampled on ref_clk; the board raises the output-gate
//          pin to the erase voltage while erase_high_voltage is high
// Notes:   Strobe timing assumes the slowest speed grade
`timescale 1ns/1ps
`default_nettype none
module aebp_host
  import aebp_pkg::*;
#(
  parameter int unsigned WAIT_CYC = WRITE_CYCLE_CYC
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              cmdValid,
  input  wire logic [1:0]        cmdOp,
  input  wire logic [ADDR_W-1:0] cmdAddr,
  input  wire logic [DATA_W-1:0] cmdData,
  input  wire logic              pollEnable,
  input  wire logic [ADDR_W-1:0] pollAddr,
  input  wire logic [DATA_W-1:0] pollData,
  output logic                   cmdReady,
  output logic                   rspValid,
  output logic [DATA_W-1:0]      rspData,
  output logic                   rspTimeout,
  output logic                   chipSelectN,
  output logic                   outputGateN,
  output logic                   writeStrobeN,
  output logic                   eraseHighVoltage,
  output logic [ADDR_W-1:0]      addrLines,
  input  wire logic [DATA_W-1:0] dataLinesIn,
  output logic [DATA_W-1:0]      dataLinesOut,
  output logic                   dataLinesOe
);
  localparam logic [1:0] OP_READ  = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_ERASE = 2'h2;

  // The wait counter is 24 bits wide and needs at least two cycles
  if (WAIT_CYC < 2 || WAIT_CYC > 32'h00ffffff) begin
    $error("WAIT_CYC out of range");
  end

  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_RSET  = 7'h02,
    ST_RACC  = 7'h04,
    ST_WSET  = 7'h08,
    ST_WPUL  = 7'h10,
    ST_WHLD  = 7'h20,
    ST_BUSY  = 7'h40
  } aebp_state_type;

  aebp_state_type    state_r, state_nxt;
  logic [23:0]       cnt_r, cnt_nxt;
  logic [11:0]       polls_r, polls_nxt;
  logic              erase_r, erase_nxt;
  logic              csN_r, csN_nxt, ogN_r, ogN_nxt, weN_r, weN_nxt, oe_r, oe_nxt;
  logic              hv_r, hv_nxt, rdy_r, rdy_nxt, rv_r, rv_nxt, to_r, to_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [DATA_W-1:0] dout_r, dout_nxt, rdat_r, rdat_nxt;
  logic              pollMode_r, pollMode_nxt;
  logic [DATA_W-1:0] syncA_r, syncB_r;

  function automatic logic [23:0] cyc(input int unsigned n);
    cyc = 24'(n - 1);
  endfunction

  // Device data is asynchronous to ref_clk
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA_r <= 8'h00;
      syncB_r <= 8'h00;
    end else begin
      syncA_r <= dataLinesIn;
      syncB_r <= syncA_r;
    end
  end

  always_comb begin
    state_nxt    = state_r;
    cnt_nxt      = (cnt_r != 24'h000000) ? cnt_r - 24'h000001 : cnt_r;
    polls_nxt    = polls_r;
    erase_nxt    = erase_r;
    csN_nxt      = csN_r;
    ogN_nxt      = ogN_r;
    weN_nxt      = weN_r;
    oe_nxt       = oe_r;
    hv_nxt       = hv_r;
    rdy_nxt      = rdy_r;
    rv_nxt       = 1'b0;
    to_nxt       = 1'b0;
    addr_nxt     = addr_r;
    dout_nxt     = dout_r;
    rdat_nxt     = rdat_r;
    pollMode_nxt = pollMode_r;
    case (state_r)
      ST_IDLE: begin
        if (cmdValid && rdy_r) begin
          rdy_nxt      = 1'b0;
          addr_nxt     = cmdAddr;
          pollMode_nxt = 1'b0;
          csN_nxt      = 1'b0;
          if (cmdOp == OP_READ) begin
            ogN_nxt   = 1'b0;
            cnt_nxt   = cyc(READ_ACCESS_CYC);
            state_nxt = ST_RACC;
          end else if (cmdOp == OP_WRITE || cmdOp == OP_ERASE) begin
            erase_nxt = (cmdOp == OP_ERASE);
            dout_nxt  = (cmdOp == OP_ERASE) ? ERASE_DATA : cmdData;
            hv_nxt    = (cmdOp == OP_ERASE);
            oe_nxt    = 1'b1;
            cnt_nxt   = cyc(ADDR_SETUP_CYC);
            state_nxt = ST_WSET;
          end else begin
            csN_nxt   = 1'b1;
            rdy_nxt   = 1'b1;
          end
        end
      end
      ST_RACC: begin
        if (cnt_r == 24'h000000) begin
          rdat_nxt  = syncB_r;
          csN_nxt   = 1'b1;
          ogN_nxt   = 1'b1;
          cnt_nxt   = cyc(RECOVERY_CYC);
          state_nxt = ST_RSET;
        end
      end
      ST_RSET: begin
        if (cnt_r == 24'h000000) begin
          if (!pollMode_r) begin
            rv_nxt    = 1'b1;
            rdy_nxt   = 1'b1;
            state_nxt = ST_IDLE;
          end else if (rdat_r == pollData) begin
            rdy_nxt   = 1'b1;
            state_nxt = ST_IDLE;
          end else if (polls_r == 12'(POLL_LIMIT)) begin
            to_nxt    = 1'b1;
            rdy_nxt   = 1'b1;
            state_nxt = ST_IDLE;
          end else begin
            polls_nxt = polls_r + 12'h001;
            csN_nxt   = 1'b0;
            ogN_nxt   = 1'b0;
            cnt_nxt   = cyc(READ_ACCESS_CYC);
            state_nxt = ST_RACC;
          end
        end
      end
      ST_WSET: begin
        if (cnt_r == 24'h000000) begin
          weN_nxt   = 1'b0;
          cnt_nxt   = cyc(WRITE_PULSE_CYC);
          state_nxt = ST_WPUL;
        end
      end
      ST_WPUL: begin
        if (cnt_r == 24'h000000) begin
          weN_nxt   = 1'b1;
          cnt_nxt   = cyc(DATA_HOLD_CYC);
          state_nxt = ST_WHLD;
        end
      end
      ST_WHLD: begin
        if (cnt_r == 24'h000000) begin
          csN_nxt   = 1'b1;
          oe_nxt    = 1'b0;
          hv_nxt    = 1'b0;
          // Erase done inside the cycle time
          cnt_nxt   = cyc(WAIT_CYC);
          polls_nxt = 12'h000;
          state_nxt = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (pollEnable && !erase_r) begin
          addr_nxt     = pollAddr;
          pollMode_nxt = 1'b1;
          csN_nxt      = 1'b0;
          ogN_nxt      = 1'b0;
          cnt_nxt      = cyc(READ_ACCESS_CYC);
          state_nxt    = ST_RACC;
        end else if (cnt_r == 24'h000000) begin
          rdy_nxt   = 1'b1;
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        csN_nxt   = 1'b1;
        ogN_nxt   = 1'b1;
        weN_nxt   = 1'b1;
        oe_nxt    = 1'b0;
        hv_nxt    = 1'b0;
        rdy_nxt   = 1'b1;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= ST_IDLE;
      cnt_r      <= 24'h000000;
      polls_r    <= 12'h000;
      erase_r    <= 1'b0;
      csN_r      <= 1'b1;
      ogN_r      <= 1'b1;
      weN_r      <= 1'b1;
      oe_r       <= 1'b0;
      hv_r       <= 1'b0;
      rdy_r      <= 1'b1;
      rv_r       <= 1'b0;
      to_r       <= 1'b0;
      addr_r     <= 9'h000;
      dout_r     <= 8'h00;
      rdat_r     <= POLL_DATA_RST;
      pollMode_r <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      cnt_r      <= cnt_nxt;
      polls_r    <= polls_nxt;
      erase_r    <= erase_nxt;
      csN_r      <= csN_nxt;
      ogN_r      <= ogN_nxt;
      weN_r      <= weN_nxt;
      oe_r       <= oe_nxt;
      hv_r       <= hv_nxt;
      rdy_r      <= rdy_nxt;
      rv_r       <= rv_nxt;
      to_r       <= to_nxt;
      addr_r     <= addr_nxt;
      dout_r     <= dout_nxt;
      rdat_r     <= rdat_nxt;
      pollMode_r <= pollMode_nxt;
    end
  end

  // Strobes live active low in their own flops, so no gate sits before the pins
  assign chipSelectN      = csN_r;
  assign outputGateN      = ogN_r;
  assign writeStrobeN     = weN_r;
  assign eraseHighVoltage = hv_r;
  assign addrLines        = addr_r;
  assign dataLinesOut     = dout_r;
  assign dataLinesOe      = oe_r;
  assign cmdReady         = rdy_r;
  assign rspValid         = rv_r;
  assign rspData          = rdat_r;
  assign rspTimeout       = to_r;
endmodule
`default_nettype wire

// ==== verif/aebp_host_assertions.sv ====
// Purpose: Pin protocol checks for the host controller
// Assumes: One clock domain, rst_n active low
// Notes:   Sees only the controller ports
`timescale 1ns/1ps
`default_nettype none
module aebp_host_assertions
  import aebp_pkg::*;
#(
  parameter int unsigned WAIT_CYC = 20
) (
  input wire logic              ref_clk,
  input wire logic              rst_n,
  input wire logic              pollEnable,
  input wire logic              chipSelectN,
  input wire logic              outputGateN,
  input wire logic              writeStrobeN,
  input wire logic              eraseHighVoltage,
  input wire logic [ADDR_W-1:0] addrLines,
  input wire logic [DATA_W-1:0] dataLinesOut,
  input wire logic              dataLinesOe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [31:0] gapCnt_r, gapCnt_nxt;
  logic        polled_r, polled_nxt;
  // Counts idle cycles since the last write pulse; saturates to stay small
  always_comb begin
    gapCnt_nxt = (gapCnt_r < WAIT_CYC) ? gapCnt_r + 32'h1 : gapCnt_r;
    polled_nxt = polled_r;
    if (!writeStrobeN) begin
      gapCnt_nxt = 32'h0;
      polled_nxt = pollEnable;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gapCnt_r <= WAIT_CYC;
      polled_r <= 1'b0;
    end else begin
      gapCnt_r <= gapCnt_nxt;
      polled_r <= polled_nxt;
    end
  end
  a_read_no_drive: assert property (!chipSelectN && !outputGateN |-> !dataLinesOe && !eraseHighVoltage)
    else $error("host drives data during a read");
  a_read_gate_hold: assert property ($fell(outputGateN) |-> !outputGateN[*8])
    else $error("read gate released too early");
  a_write_gate_high: assert property (!writeStrobeN |-> outputGateN && !chipSelectN && dataLinesOe)
    else $error("write strobe without select, gate high and data");
  a_addr_before_strobe: assert property ($fell(writeStrobeN) |-> $stable(addrLines) && !$past(chipSelectN))
    else $error("address not settled before write strobe");
  a_data_hold: assert property ($rose(writeStrobeN) |-> (dataLinesOe && $stable(dataLinesOut))[*2])
    else $error("write data not held after strobe");
  a_strobe_width: assert property ($fell(writeStrobeN) |-> !writeStrobeN[*6])
    else $error("write pulse too short");
  a_reset_idle: assert property (disable iff (1'b0) !rst_n |-> chipSelectN && writeStrobeN && !dataLinesOe)
    else $error("pins not idle in reset");
  a_erase_ones: assert property (eraseHighVoltage && dataLinesOe |-> outputGateN && dataLinesOut == ERASE_DATA)
    else $error("erase without all ones");
  a_write_spacing: assert property ($fell(writeStrobeN) && !polled_r |-> gapCnt_r >= WAIT_CYC)
    else $error("write started before cycle time");
endmodule
bind aebp_host aebp_host_assertions #(.WAIT_CYC(WAIT_CYC)) chk_i (.ref_clk, .rst_n, .pollEnable, .chipSelectN,
  .outputGateN, .writeStrobeN, .eraseHighVoltage, .addrLines, .dataLinesOut, .dataLinesOe);
`default_nettype wire

// ==== verif/aebp_dev_model.sv ====
// Purpose: Behavioural 512 x 8 nonvolatile memory on the strobe pins
// Assumes: Programming time shorter than the host wait
// Notes:   Released data lines toggle so stale values never match
`timescale 1ns/1ps
`default_nettype none
module aebp_dev_model
  import aebp_pkg::*;
#(
  parameter int unsigned PROG_NS = 600
) (
  input  wire logic              chipSelectN,
  input  wire logic              outputGateN,
  input  wire logic              writeStrobeN,
  input  wire logic              eraseHighVoltage,
  input  wire logic [ADDR_W-1:0] addrLines,
  input  wire logic [DATA_W-1:0] dataLinesOut,
  output logic      [DATA_W-1:0] dataLinesIn
);
  logic [DATA_W-1:0] mem [512];
  logic [ADDR_W-1:0] addrLatch;
  logic [DATA_W-1:0] junk = 8'h5a;
  logic              busy = 1'b0;
  realtime           tFall = 0.0;
  initial for (int i = 0; i < 512; i++) mem[i] = 8'h00;
  always #13 junk = ~junk;
  // Drive only when selected, gated and idle
  assign dataLinesIn = (!chipSelectN && !outputGateN && !busy) ? mem[addrLines] : junk;
  always @(negedge chipSelectN or negedge writeStrobeN) begin
    if (!chipSelectN && !writeStrobeN) begin
      addrLatch = addrLines;
      tFall = $realtime;
    end
  end
  always @(posedge chipSelectN or posedge writeStrobeN) begin
    if ((chipSelectN ^ writeStrobeN) && outputGateN && !busy && $realtime - tFall >= 20.0) begin
      if (eraseHighVoltage && dataLinesOut == 8'hff)
        for (int i = 0; i < 512; i++) mem[i] = 8'hff;
      else
        mem[addrLatch] = dataLinesOut;
      busy = 1'b1;
      busy <= #(PROG_NS) 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== verif/async_eeprom_byte_port_bench.sv ====
// Purpose: Self-checking bench for the host controller and memory model
// Assumes: Shortened write wait of 20 cycles
// Notes:   Address 0 is kept as the poll location until the timeout test moves it to 7
`timescale 1ns/1ps
`default_nettype none
module async_eeprom_byte_port_bench
  import aebp_pkg::*;
;
  localparam int unsigned WAIT = 20;
  logic              ref_clk = 1'b0;
  logic              rst_n, cmdValid, pollEnable;
  logic [1:0]        cmdOp;
  logic [ADDR_W-1:0] cmdAddr, pollAddr, addrLines;
  logic [DATA_W-1:0] cmdData, pollData, rspData, dataLinesIn, dataLinesOut;
  logic              cmdReady, rspValid, rspTimeout, chipSelectN, outputGateN, writeStrobeN;
  logic              eraseHighVoltage, dataLinesOe;
  logic [DATA_W-1:0] expMem [512];
  int                errors = 0;
  int                tests_run = 0;
  int                a, b;
  always #20 ref_clk = ~ref_clk;
  aebp_host #(.WAIT_CYC(WAIT)) uut (.ref_clk, .rst_n, .cmdValid, .cmdOp, .cmdAddr, .cmdData, .pollEnable,
    .pollAddr, .pollData, .cmdReady, .rspValid, .rspData, .rspTimeout, .chipSelectN, .outputGateN,
    .writeStrobeN, .eraseHighVoltage, .addrLines, .dataLinesIn, .dataLinesOut, .dataLinesOe);
  aebp_dev_model dev (.chipSelectN, .outputGateN, .writeStrobeN, .eraseHighVoltage, .addrLines,
    .dataLinesOut, .dataLinesIn);
  task automatic conclude();
    if (errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic waitFor(input bit rsp, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while ((rsp ? rspValid : cmdReady) !== 1'b1 && n < lim);
    if (n >= lim) begin
      errors++;
      conclude();
    end
  endtask
  task automatic issue(input logic [1:0] op, input int ad, input logic [DATA_W-1:0] d, input logic pe);
    waitFor(1'b0, 3000);
    @(posedge ref_clk);
    cmdValid <= 1'b1;
    cmdOp <= op;
    cmdAddr <= ADDR_W'(ad);
    cmdData <= d;
    pollEnable <= pe;
    pollData <= expMem[0];
    @(posedge ref_clk);
    cmdValid <= 1'b0;
    if (op == 2'd0) begin
      waitFor(1'b1, 3000);
      chk(rspData, expMem[ad]);
    end else if (op == 2'd3) begin
      @(negedge ref_clk);
      chk({6'h0, chipSelectN, cmdReady}, 8'h03);
    end else if (op == 2'd1) expMem[ad] = d;
    else for (int i = 0; i < 512; i++) expMem[i] = 8'hff;
  endtask
  initial begin
    rst_n = 1'b1;
    cmdValid = 1'b0;
    cmdOp = 2'd0;
    cmdAddr = '0;
    cmdData = '0;
    pollEnable = 1'b0;
    pollAddr = '0;
    pollData = '0;
    void'($urandom(32'hc5cf));
    for (int i = 0; i < 512; i++) expMem[i] = 8'h00;
    // A clean falling edge makes sure the asynchronous reset is seen before the first clock
    #1 rst_n = 1'b0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    chk({5'h0, chipSelectN, writeStrobeN, cmdReady}, 8'h07);
    issue(2'd1, 511, 8'h3c, 1'b0);
    issue(2'd1, 1, 8'hc3, 1'b1);
    issue(2'd0, 511, 8'h00, 1'b0);
    issue(2'd0, 1, 8'h00, 1'b0);
    issue(2'd3, 1, 8'h11, 1'b0);
    issue(2'd0, 1, 8'h00, 1'b0);
    repeat (10) begin
      a = $urandom_range(511, 1);
      b = $urandom_range(511, 1);
      issue(2'd1, a, 8'($urandom), 1'($urandom));
      issue(2'd1, b, 8'($urandom), 1'($urandom));
      issue(2'd0, a, 8'h00, 1'b0);
      issue(2'd0, b, 8'h00, 1'b0);
    end
    issue(2'd2, 5, 8'h00, 1'b1);
    issue(2'd0, 0, 8'h00, 1'b0);
    issue(2'd0, 511, 8'h00, 1'b0);
    issue(2'd1, 7, 8'h5e, 1'b1);
    issue(2'd0, 7, 8'h00, 1'b0);
    // Poll a location that never holds the known byte, forcing the give-up path
    @(posedge ref_clk);
    pollAddr <= 9'h007;
    issue(2'd1, 9, 8'h77, 1'b1);
    waitFor(1'b0, 70000);
    chk({7'h0, rspTimeout}, 8'h01);
    issue(2'd0, 9, 8'h00, 1'b0);
    conclude();
  end
endmodule
`default_nettype wire
